//--- hdl/jtag_security_gate.sv
// Test port enable and flash security gate with AHB-Lite registers
`include "jtag_security_gate_map.svh"
`default_nettype none
module jtag_security_gate (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic por_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic port_select_product_term,
  output logic port_on
);
  jtag_security_gate_pkg::eng_state_t state_r;
  jtag_security_gate_pkg::cmd_op_t op_r;
  jtag_security_gate_pkg::cmd_t cmd;
  jtag_security_gate_pkg::resp_t resp_r;
  jtag_security_gate_pkg::resp_t resp_nxt;
  jtag_security_gate_pkg::status_t status;
  logic [7:0] mem_r [16];
  logic [3:0] cnt_r;
  logic [2:0] sect_r;
  logic secured_r, dedicate_r, link_on_r, resp_tgl_r, tdo_oe_r, port_on_r;
  logic [7:0] prot_r;
  logic [2:0] s1_r, s2_r;
  logic cmd_seen_r, sw_en_r;
  logic rd_pend_r, wr_pend_r;
  logic [9:0] idx_r;
  logic hi_ok_r;
  logic [31:0] hrdata_r;
  logic [15:0] sh_in_r, cmd_word_r, resp_sh_r;
  logic [3:0] bit_cnt_r;
  logic cmd_tgl_tck_r, resp_seen_r;
  logic [1:0] t1_r, t2_r;
  logic dev_rst, pt_sync, cmd_fire, abort, ap;
  logic post, go_busy, prog_en, cfg_en, erase_all, erase_sect, consume, link_nxt;
  function automatic logic [2:0] sect_of(input logic [3:0] a);
    sect_of = a[3:1];
  endfunction
  function automatic logic [1:0] reg_sel(input logic ok, input logic [9:0] idx);
    reg_sel = 2'h0;
    if (ok && idx == `TPE_INDEX) begin
      reg_sel = 2'h1;
    end else if (ok && idx == `STATUS_INDEX) begin
      reg_sel = 2'h2;
    end else if (ok && idx == `PROTECT_INDEX) begin
      reg_sel = 2'h3;
    end
  endfunction

  // Bus register slave; reads take one wait state so hrdata is a flop
  assign ap = hsel & htrans[1] & hready;
  assign hreadyout = !rd_pend_r;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend_r <= 1'b0;
      wr_pend_r <= 1'b0;
      idx_r <= 10'h000;
      hi_ok_r <= 1'b0;
    end else begin
      rd_pend_r <= ap & !hwrite;
      wr_pend_r <= ap & hwrite;
      if (ap) begin
        idx_r <= haddr[11:2];
        hi_ok_r <= (haddr[31:12] == `CTRL_BASE_HI);
      end
    end
  end
  // Bus reset doubles as device reset and drops the software enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_en_r <= 1'b0;
    end else if (wr_pend_r && reg_sel(hi_ok_r, idx_r) == 2'h1) begin
      sw_en_r <= hwdata[`TPE_EN_BIT];
    end
  end
  assign status = '{zero: 3'h0, busy: state_r == jtag_security_gate_pkg::ENG_BUSY,
    link_on: link_on_r, port_on: port_on_r, dedicated: dedicate_r, secured: secured_r};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rd_pend_r) begin
      case (reg_sel(hi_ok_r, idx_r))
        2'h1: hrdata_r <= {31'h0000_0000, sw_en_r};
        2'h2: hrdata_r <= {24'h00_0000, status};
        2'h3: hrdata_r <= {24'h00_0000, prot_r};
        default: hrdata_r <= 32'h0000_0000;
      endcase
    end
  end
  // Level and event inputs into hclk; only s2 is read
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
    end else begin
      s1_r <= {cmd_tgl_tck_r, port_select_product_term, !hresetn};
      s2_r <= s1_r;
    end
  end
  assign dev_rst = s2_r[0];
  assign pt_sync = s2_r[1];
  assign cmd_fire = s2_r[2] ^ cmd_seen_r;
  // Reset only reaches the port when it is not dedicated
  assign abort = dev_rst & !dedicate_r;
  // Word is stable: tck side changes it only on the edge that makes the next toggle
  assign cmd = jtag_security_gate_pkg::cmd_t'(cmd_word_r);
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      cmd_seen_r <= 1'b0;
      port_on_r <= 1'b0;
    end else begin
      if (consume) begin
        cmd_seen_r <= s2_r[2];
      end
      port_on_r <= dedicate_r | sw_en_r | pt_sync;
    end
  end
  assign port_on = port_on_r;
  always_comb begin
    post = 1'b0;
    go_busy = 1'b0;
    prog_en = 1'b0;
    cfg_en = 1'b0;
    erase_all = 1'b0;
    erase_sect = 1'b0;
    consume = 1'b0;
    link_nxt = link_on_r & port_on_r & !abort;
    resp_nxt = '0;
    resp_nxt.secured = secured_r;
    resp_nxt.busy = (state_r == jtag_security_gate_pkg::ENG_BUSY);
    if (state_r == jtag_security_gate_pkg::ENG_BUSY) begin
      if (abort) begin
        post = 1'b1;
        resp_nxt.refused = 1'b1;
      end else if (cnt_r == 4'h0) begin
        post = 1'b1;
        resp_nxt.busy = 1'b0;
        erase_all = (op_r == jtag_security_gate_pkg::OP_CHIP_ERASE);
        erase_sect = (op_r == jtag_security_gate_pkg::OP_SECTOR_ERASE);
      end else if (cmd_fire) begin
        consume = 1'b1;
        post = 1'b1;
        resp_nxt.refused = 1'b1;
      end
    end else if (cmd_fire) begin
      consume = 1'b1;
      post = 1'b1;
      if (abort || !port_on_r) begin
        resp_nxt.refused = 1'b1;
      end else if (cmd.op == jtag_security_gate_pkg::OP_ENABLE) begin
        link_nxt = 1'b1;
      end else if (!link_on_r) begin
        resp_nxt.refused = 1'b1;
      end else begin
        case (cmd.op)
          jtag_security_gate_pkg::OP_DISABLE: begin
            link_nxt = 1'b0;
          end
          jtag_security_gate_pkg::OP_READ: begin
            if (secured_r) begin
              resp_nxt.refused = 1'b1;
            end else begin
              resp_nxt.data = mem_r[cmd.addr];
            end
          end
          jtag_security_gate_pkg::OP_VERIFY: begin
            if (secured_r) begin
              resp_nxt.refused = 1'b1;
            end else begin
              resp_nxt.data = {7'h00, mem_r[cmd.addr] == cmd.data};
            end
          end
          jtag_security_gate_pkg::OP_PROGRAM: begin
            resp_nxt.refused = secured_r;
            prog_en = !secured_r;
          end
          jtag_security_gate_pkg::OP_CONFIG: begin
            resp_nxt.refused = secured_r;
            cfg_en = !secured_r;
          end
          jtag_security_gate_pkg::OP_SECTOR_ERASE: begin
            if (secured_r || prot_r[sect_of(cmd.addr)]) begin
              resp_nxt.refused = 1'b1;
            end else begin
              go_busy = 1'b1;
              post = 1'b0;
            end
          end
          jtag_security_gate_pkg::OP_CHIP_ERASE: begin
            go_busy = 1'b1;
            post = 1'b0;
          end
          default: begin
            resp_nxt.refused = 1'b1;
          end
        endcase
      end
    end
  end
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      state_r <= jtag_security_gate_pkg::ENG_IDLE;
      cnt_r <= 4'h0;
      op_r <= jtag_security_gate_pkg::OP_NOP;
      sect_r <= 3'h0;
    end else begin
      case (state_r)
        jtag_security_gate_pkg::ENG_IDLE: begin
          if (go_busy) begin
            state_r <= jtag_security_gate_pkg::ENG_BUSY;
            cnt_r <= `ERASE_CYCLES;
            op_r <= cmd.op;
            sect_r <= sect_of(cmd.addr);
          end
        end
        default: begin
          if (abort || cnt_r == 4'h0) begin
            state_r <= jtag_security_gate_pkg::ENG_IDLE;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
      endcase
    end
  end
  // Nonvolatile image; power-on and chip erase load factory state
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      secured_r <= 1'b0;
      dedicate_r <= 1'b0;
      prot_r <= `NV_FACTORY_PROT;
      for (int i = 0; i < 16; i++) begin
        mem_r[i] <= `FLASH_BLANK;
      end
    end else if (erase_all) begin
      secured_r <= 1'b0;
      dedicate_r <= 1'b0;
      prot_r <= `NV_FACTORY_PROT;
      for (int i = 0; i < 16; i++) begin
        mem_r[i] <= `FLASH_BLANK;
      end
    end else if (erase_sect) begin
      mem_r[{sect_r, 1'b0}] <= `FLASH_BLANK;
      mem_r[{sect_r, 1'b1}] <= `FLASH_BLANK;
    end else if (prog_en) begin
      mem_r[cmd.addr] <= mem_r[cmd.addr] & cmd.data;
    end else if (cfg_en) begin
      if (cmd.addr[`CFG_SEL_BIT]) begin
        secured_r <= secured_r | cmd.data[`CFG_SEC_BIT];
        dedicate_r <= dedicate_r | cmd.data[`CFG_DED_BIT];
      end else begin
        prot_r <= prot_r | cmd.data;
      end
    end
  end
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      link_on_r <= 1'b0;
      tdo_oe_r <= 1'b0;
      resp_r <= '0;
      resp_tgl_r <= 1'b0;
    end else begin
      link_on_r <= link_nxt;
      tdo_oe_r <= link_on_r & port_on_r;
      if (post) begin
        resp_r <= resp_nxt;
        resp_tgl_r <= !resp_tgl_r;
      end
    end
  end
  assign tdo_oe = tdo_oe_r;
  // Link side: frames are 16 tck edges with tms high
  always_ff @(posedge tck or negedge por_n) begin
    if (!por_n) begin
      t1_r <= 2'h0;
      t2_r <= 2'h0;
    end else begin
      t1_r <= {resp_tgl_r, port_on_r};
      t2_r <= t1_r;
    end
  end
  always_ff @(posedge tck or negedge por_n) begin
    if (!por_n) begin
      sh_in_r <= 16'h0000;
      bit_cnt_r <= 4'h0;
      cmd_word_r <= 16'h0000;
      cmd_tgl_tck_r <= 1'b0;
    end else if (t2_r[0] && tms) begin
      sh_in_r <= {sh_in_r[14:0], tdi};
      bit_cnt_r <= bit_cnt_r + 4'h1;
      if (bit_cnt_r == `FRAME_LAST) begin
        cmd_word_r <= {sh_in_r[14:0], tdi};
        cmd_tgl_tck_r <= !cmd_tgl_tck_r;
      end
    end
  end
  // Answer of the previous command goes out during the next frame
  always_ff @(posedge tck or negedge por_n) begin
    if (!por_n) begin
      resp_sh_r <= 16'h0000;
      resp_seen_r <= 1'b0;
    end else if (t2_r[0] && tms) begin
      if (bit_cnt_r == 4'h0) begin
        resp_seen_r <= t2_r[1];
        resp_sh_r <= (t2_r[1] != resp_seen_r) ? resp_r : 16'h0000;
      end else begin
        resp_sh_r <= {resp_sh_r[14:0], 1'b0};
      end
    end
  end
  assign tdo = resp_sh_r[15];
  logic idle_fire;
  assign idle_fire = cmd_fire && state_r == jtag_security_gate_pkg::ENG_IDLE && !abort && link_on_r
    && port_on_r;
  secured_read_a: assert property (@(posedge hclk) disable iff (!por_n)
    idle_fire && secured_r && cmd.op == jtag_security_gate_pkg::OP_READ |=> resp_r.refused && resp_r.data == 8'h00)
    else $error("secured read not refused");
  chip_erase_a: assert property (@(posedge hclk) disable iff (!por_n)
    idle_fire && cmd.op == jtag_security_gate_pkg::OP_CHIP_ERASE |=> state_r == jtag_security_gate_pkg::ENG_BUSY)
    else $error("chip erase not started");
  secured_block_a: assert property (@(posedge hclk) disable iff (!por_n)
    idle_fire && secured_r && cmd.op == jtag_security_gate_pkg::OP_PROGRAM |=> resp_r.refused && $stable(mem_r[0]))
    else $error("secured program not blocked");
  erase_clears_a: assert property (@(posedge hclk) disable iff (!por_n)
    erase_all |=> !secured_r && prot_r == 8'h00 && mem_r[5] == 8'hFF)
    else $error("chip erase left part secured");
  sector_guard_a: assert property (@(posedge hclk) disable iff (!por_n)
    idle_fire && cmd.op == jtag_security_gate_pkg::OP_SECTOR_ERASE && prot_r[cmd.addr[3:1]]
    |=> resp_r.refused && state_r == jtag_security_gate_pkg::ENG_IDLE)
    else $error("protected sector erase accepted");
  enable_bit_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_r && hi_ok_r && idx_r == `TPE_INDEX |=> sw_en_r == $past(hwdata[0]) ##1 (port_on_r || !$past(sw_en_r)))
    else $error("enable bit not applied");
  dedicated_hold_a: assert property (@(posedge hclk) disable iff (!por_n)
    state_r == jtag_security_gate_pkg::ENG_BUSY && cnt_r > 4'h1 && dedicate_r |=> state_r == jtag_security_gate_pkg::ENG_BUSY)
    else $error("dedicated port operation aborted");
  reset_abort_a: assert property (@(posedge hclk) disable iff (!por_n)
    abort |=> state_r == jtag_security_gate_pkg::ENG_IDLE && !link_on_r ##1 !tdo_oe_r)
    else $error("reset did not abort port");
  tdo_quiet_a: assert property (@(posedge hclk) disable iff (!por_n)
    !link_on_r |=> !tdo_oe_r)
    else $error("tdo driven before enable");
  erase_done_c: cover property (@(posedge hclk) disable iff (!por_n) erase_all ##1 !secured_r);
  refused_c: cover property (@(posedge hclk) disable iff (!por_n) post && resp_nxt.refused && secured_r);
  read_c: cover property (@(posedge hclk) disable iff (!hresetn) rd_pend_r ##1 hreadyout);
  sector_c: cover property (@(posedge hclk) disable iff (!por_n) erase_sect);
endmodule
`default_nettype wire

//--- hdl/jtag_security_gate_map.svh
// Offsets, field positions, reset values and timing counts of the test port gate
`ifndef JTAG_SECURITY_GATE_MAP_SVH
`define JTAG_SECURITY_GATE_MAP_SVH
`define CTRL_BASE_HI 20'h0_0000
`define TPE_INDEX 10'h0C7
`define STATUS_INDEX 10'h0C8
`define PROTECT_INDEX 10'h0C9
`define TPE_EN_BIT 0
`define CFG_SEC_BIT 0
`define CFG_DED_BIT 1
`define CFG_SEL_BIT 3
`define FLASH_BLANK 8'hFF
`define NV_FACTORY_PROT 8'h00
`define ERASE_CYCLES 4'h8
`define FRAME_LAST 4'hF
`endif

//--- hdl/jtag_security_gate_pkg.sv
// Types shared by the test port gate
`default_nettype none
package jtag_security_gate_pkg;
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_ENABLE = 4'h1,
    OP_READ = 4'h2,
    OP_PROGRAM = 4'h3,
    OP_SECTOR_ERASE = 4'h4,
    OP_CHIP_ERASE = 4'h5,
    OP_VERIFY = 4'h6,
    OP_DISABLE = 4'h7,
    OP_CONFIG = 4'h8
  } cmd_op_t;
  typedef struct packed {
    cmd_op_t op;
    logic [3:0] addr;
    logic [7:0] data;
  } cmd_t;
  typedef struct packed {
    logic refused;
    logic busy;
    logic secured;
    logic [4:0] zero;
    logic [7:0] data;
  } resp_t;
  typedef struct packed {
    logic [2:0] zero;
    logic busy;
    logic link_on;
    logic port_on;
    logic dedicated;
    logic secured;
  } status_t;
  typedef enum logic [0:0] {
    ENG_IDLE = 1'b0,
    ENG_BUSY = 1'b1
  } eng_state_t;
endpackage
`default_nettype wire

//--- dv/jtag_ctrl_model.sv
// Behavioural external test controller driving frames into the test port
`default_nettype none
module jtag_ctrl_model (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last_r;
  initial begin
    tck = 1'b0;
    tms = 1'b0;
    tdi = 1'b0;
    last_r = 1'b0;
  end
  // Clock stands still outside frames; the gap covers command handling
  task automatic frame(input logic [15:0] w, output logic [15:0] r, input int gap);
    #17;
    // Two idle edges carry port state and answer flag into the tck side
    for (int p = 0; p < 2; p++) begin
      #62.5 tck = 1'b1;
      #62.5 tck = 1'b0;
    end
    for (int k = 15; k >= 0; k--) begin
      tms = 1'b1;
      tdi = w[k];
      #62.5 tck = 1'b1;
      // Undriven answer line seen as the inverse of the last bit
      #31.2 r[k] = tdo_oe ? tdo : ~last_r;
      last_r = r[k];
      #31.3 tck = 1'b0;
    end
    tms = 1'b0;
    tdi = ~w[0];
    #(gap);
  endtask
endmodule
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the test port gate
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
  $display("Error at %0t: got %h want %h", $time, (a), (b)); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] exp;
    logic [15:0] msk;
  } row_t;
  localparam logic [31:0] TPE_A = 32'h0000_031C;
  localparam logic [31:0] PROT_A = 32'h0000_0324;
  localparam logic [31:0] UNM_A = 32'h0000_0100;
  logic hclk, hresetn, por_n, hsel, hwrite, hreadyout, hresp;
  logic tck, tms, tdi, tdo, tdo_oe, pst, port_on;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] r;
  int mismatches, checks_done;
  row_t rows [20] = '{
    '{16'h2300, 16'h8000, 16'h8000},
    '{16'h1000, 16'h0000, 16'h8000},
    '{16'h2300, 16'h00FF, 16'hFFFF},
    '{16'h335A, 16'h0000, 16'h8000},
    '{16'h2300, 16'h005A, 16'hFFFF},
    '{16'h635A, 16'h0000, 16'h8000},
    '{16'h8801, 16'h0000, 16'h8000},
    '{16'h2300, 16'hA000, 16'hA000},
    '{16'h3300, 16'hA000, 16'hA000},
    '{16'h4200, 16'hA000, 16'hA000},
    '{16'h6300, 16'hA000, 16'hA000},
    '{16'h8800, 16'hA000, 16'hA000},
    '{16'h5000, 16'h0000, 16'hC000},
    '{16'h2300, 16'h00FF, 16'hFFFF},
    '{16'h335A, 16'h0000, 16'h8000},
    '{16'h8002, 16'h0000, 16'h8000},
    '{16'h4200, 16'h8000, 16'h8000},
    '{16'h4400, 16'h0000, 16'h8000},
    '{16'h3500, 16'h0000, 16'h8000},
    '{16'h0000, 16'h8000, 16'h8000}
  };

  jtag_security_gate jtag_security_gate_i (
    .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .port_select_product_term(pst), .port_on(port_on)
  );
  jtag_ctrl_model jtag_ctrl_model_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    @(negedge hclk);
    while (hreadyout !== 1'b1 && n < 50) begin
      @(negedge hclk);
      n++;
    end
    if (n == 50) begin
      mismatches++;
      $display("Error at %0t: bus timeout", $time);
      finish_test();
    end
    @(posedge hclk);
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask

  task automatic wait_port(input logic e);
    for (int n = 0; n < 20 && port_on !== e; n++) @(posedge hclk);
    `CHK(port_on, e)
    if (port_on !== e) finish_test();
  endtask

  // Command frame, then an empty frame that carries its answer out
  task automatic xfer(input logic [15:0] c, output logic [15:0] q);
    jtag_ctrl_model_i.frame(c, q, 3000);
    jtag_ctrl_model_i.frame(16'h0000, q, 3000);
  endtask

  task automatic rst_pulse();
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask

  initial begin
    hresetn = 1'b0;
    por_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    pst = 1'b0;
    mismatches = 0;
    checks_done = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    por_n <= 1'b1;
    @(posedge hclk);
    pst <= 1'b1;
    wait_port(1'b1);
    pst <= 1'b0;
    wait_port(1'b0);
    bus(1'b1, TPE_A, 32'h0000_0001, rd);
    bus(1'b0, TPE_A, 32'h0000_0000, rd);
    `CHK(rd, 32'h0000_0001)
    wait_port(1'b1);
    bus(1'b1, TPE_A, 32'h0000_0000, rd);
    wait_port(1'b0);
    bus(1'b1, TPE_A, 32'h0000_0001, rd);
    wait_port(1'b1);
    bus(1'b0, UNM_A, 32'h0000_0000, rd);
    `CHK(rd, 32'h0000_0000)
    `CHK(hresp, 1'b0)
    `CHK(tdo_oe, 1'b0)
    $display("Enable test done");
    foreach (rows[i]) begin
      xfer(rows[i].cmd, r);
      `CHK(r & rows[i].msk, rows[i].exp)
    end
    `CHK(tdo_oe, 1'b1)
    $display("Command table done");
    bus(1'b0, PROT_A, 32'h0000_0000, rd);
    `CHK(rd, 32'h0000_0002)
    // Reset lands while the chip erase is still running
    jtag_ctrl_model_i.frame(16'h5000, r, 300);
    rst_pulse();
    wait_port(1'b0);
    bus(1'b0, TPE_A, 32'h0000_0000, rd);
    `CHK(rd, 32'h0000_0000)
    bus(1'b0, PROT_A, 32'h0000_0000, rd);
    `CHK(rd, 32'h0000_0002)
    bus(1'b1, TPE_A, 32'h0000_0001, rd);
    wait_port(1'b1);
    xfer(16'h1000, r);
    xfer(16'h2500, r);
    `CHK(r, 16'h0000)
    $display("Abort test done");
    xfer(16'h8802, r);
    `CHK(r & 16'h8000, 16'h0000)
    bus(1'b1, TPE_A, 32'h0000_0000, rd);
    repeat (10) @(posedge hclk);
    `CHK(port_on, 1'b1)
    // Sector erase still running when reset arrives
    jtag_ctrl_model_i.frame(16'h4400, r, 300);
    rst_pulse();
    repeat (5) @(posedge hclk);
    `CHK(port_on, 1'b1)
    xfer(16'h2500, r);
    `CHK(r, 16'h00FF)
    $display("Dedicated test done");
    finish_test();
  end
endmodule
`default_nettype wire
